// ===== efcs_sequencer.sv
// Exposure and frame control sequencer: exposure, global sampling and readout timing
// Assumes request pins asynchronous, configuration static between frames, one pixel clock
//
// Summary of operation
// - Full external: exposure request edge starts exposure
// - Full external: frame request starts sampling, then readout
// - Full external exposure spans request to request
// - Sampling and readout lengths come from configuration
// - Exposure request during exposure restarts it
// - Frame request during readout aborts, restarts sampling
// - Programmed external: exposure ends after programmed time
// - Frame request ignored in programmed, triggered modes
// - Expiry during sampling restarts sampling, corrupt data
// - Expiry during readout aborts readout, restarts sampling
// - Triggered: request starts programmed exposure, sample, readout
// - Triggered: programmed frame count at frame time
// - Non-last readout: next exposure ends one frame later
// - Last triggered readout completes then returns idle
// - Minimum frame time: sampling follows readout immediately
// - Early request extends sequence, capped at 255
// - Late request starts a fresh complete sequence
// - Short new exposure delayed to end with frame
// - Long new exposure starts at once, rate drops
// - Three-bit mode field selects operating mode
// - Readout end: idle, or wait for pending exposure
`timescale 1ns/1ps
module efcs_sequencer
  import efcs_pkg::*;
(
  input  wire logic         clk_in,             // Pixel clock, 40 MHz
  input  wire logic         rst_in,             // Hard reset, async, active high
  input  wire logic         soft_rst_n_in,      // Soft reset, async, active low
  input  wire logic         exposure_request_in, // Exposure request pin
  input  wire logic         frame_request_in,   // Frame request pin
  input  wire efcs_cfg_t    cfg_in,             // Mode and timing configuration
  output efcs_status_t      status_out          // Sequencer state
);
  logic          rst_all;
  logic          exp_rise;
  logic          frm_rise;
  efcs_frame_t   fr_q;
  efcs_frame_t   fr_d;
  logic          exp_on_q;
  logic          exp_on_d;
  logic          wait_q;
  logic          wait_d;
  logic          corrupt_q;
  logic          corrupt_d;
  logic          exposed_q;
  logic          exposed_d;
  logic [7:0]    left_q;
  logic [7:0]    left_d;
  logic          start_global_sample_state;
  logic          global_sample_state_bad;
  logic          exp_load;
  logic          exp_stop;
  logic          exp_done;
  logic          dly_load;
  logic [CNT_W-1:0] dly_len;
  logic          dly_done;
  logic          dly_busy;
  logic          smp_done;
  logic          rd_load;
  logic          rd_done;
  logic          rd_busy;
  logic [CNT_W-1:0] rd_left;
  logic          rd_last;
  logic          ft_load;
  logic [CNT_W-1:0] ft_left;
  logic          ft_busy;
  logic          trig;
  logic          ext;
  logic          last_rd;
  logic [8:0]    sum_left;

  assign rst_all = rst_in | ~soft_rst_n_in;
  assign trig    = (cfg_in.mode == MODE_TRIG_INT);
  assign ext     = (cfg_in.mode == MODE_FULL_EXT) || (cfg_in.mode == MODE_PROG_EXT);

  efcs_edge_sync u_exp_sync (
    .clk_in   (clk_in),
    .rst_in   (rst_all),
    .pin_in   (exposure_request_in),
    .rise_out (exp_rise)
  );

  efcs_edge_sync u_frm_sync (
    .clk_in   (clk_in),
    .rst_in   (rst_all),
    .pin_in   (frame_request_in),
    .rise_out (frm_rise)
  );

  // Programmed exposure interval
  efcs_timer u_exp_tmr (
    .clk_in   (clk_in),
    .rst_in   (rst_all),
    .load_in  (exp_load),
    .len_in   (cfg_in.exp_time),
    .stop_in  (exp_stop),
    .done_out (exp_done),
    .busy_out (),
    .left_out ()
  );

  // Delay before a deferred exposure start
  efcs_timer u_dly_tmr (
    .clk_in   (clk_in),
    .rst_in   (rst_all),
    .load_in  (dly_load),
    .len_in   (dly_len),
    .stop_in  (rst_all),
    .done_out (dly_done),
    .busy_out (dly_busy),
    .left_out ()
  );

  // Global sampling duration
  efcs_timer u_smp_tmr (
    .clk_in   (clk_in),
    .rst_in   (rst_all),
    .load_in  (start_global_sample_state),
    .len_in   (cfg_in.sample_len),
    .stop_in  (1'b0),
    .done_out (smp_done),
    .busy_out (),
    .left_out ()
  );

  // Readout duration
  efcs_timer u_rd_tmr (
    .clk_in   (clk_in),
    .rst_in   (rst_all),
    .load_in  (rd_load),
    .len_in   (cfg_in.readout_len),
    .stop_in  (start_global_sample_state),
    .done_out (rd_done),
    .busy_out (rd_busy),
    .left_out (rd_left)
  );

  // Frame time measured from each triggered-mode sampling start
  efcs_timer u_ft_tmr (
    .clk_in   (clk_in),
    .rst_in   (rst_all),
    .load_in  (ft_load),
    .len_in   (cfg_in.frame_time),
    .stop_in  (1'b0),
    .done_out (),
    .busy_out (ft_busy),
    .left_out (ft_left)
  );

  assign rd_load = smp_done;
  assign ft_load = start_global_sample_state && trig;
  // Frames still to be sampled after the current one; zero marks the last readout
  assign last_rd = (left_q == 8'h00);
  assign rd_last = (rd_left == CNT_ONE);
  assign sum_left = {1'b0, left_q} + {1'b0, cfg_in.seq_len};

  always_comb begin
    fr_d       = fr_q;
    exp_on_d   = exp_on_q;
    wait_d     = wait_q;
    corrupt_d  = corrupt_q;
    exposed_d  = exposed_q;
    left_d     = left_q;
    start_global_sample_state = 1'b0;
    global_sample_state_bad   = 1'b0;
    exp_load   = 1'b0;
    exp_stop   = 1'b0;
    dly_load   = 1'b0;
    dly_len    = CNT_ONE;

    // Sampling completion hands over to readout
    if (smp_done) begin
      fr_d = FR_READ;
    end

    if (ext) begin
      if (exp_rise) begin
        exp_on_d  = 1'b1;
        exposed_d = 1'b0;
        exp_load  = (cfg_in.mode == MODE_PROG_EXT);
        if (fr_q == FR_SAMPLE) begin
          corrupt_d = 1'b1;
        end
      end
      if (cfg_in.mode == MODE_FULL_EXT && frm_rise) begin
        start_global_sample_state = 1'b1;
        global_sample_state_bad   = (fr_q == FR_SAMPLE) || !exp_on_q;
        exp_on_d   = 1'b0;
      end else if (cfg_in.mode == MODE_PROG_EXT && exp_done) begin
        start_global_sample_state = 1'b1;
        global_sample_state_bad   = (fr_q == FR_SAMPLE);
        exp_on_d   = 1'b0;
      end
    end else if (trig) begin
      // Frame request pulses never reach the trigger path
      if (exp_rise) begin
        if (fr_q == FR_IDLE && !exp_on_q && !dly_busy) begin
          exp_on_d = 1'b1;
          exp_load = 1'b1;
          left_d   = cfg_in.seq_len;
        end else if (!(fr_q == FR_READ && last_rd)) begin
          left_d = (sum_left > {1'b0, SEQ_MAX}) ? SEQ_MAX : sum_left[7:0];
        end else begin
          left_d = cfg_in.seq_len;
          if (ft_busy && (cfg_in.exp_time + CNT_ONE) < ft_left) begin
            dly_load = 1'b1;
            dly_len  = ft_left - cfg_in.exp_time - CNT_ONE;
          end else begin
            exp_on_d = 1'b1;
            exp_load = 1'b1;
          end
        end
      end
      // Schedule the next exposure from the readout start so it ends one frame time on
      if ((fr_q == FR_READ || smp_done) && !last_rd && !exp_on_q && !dly_busy
          && !wait_q) begin
        wait_d = 1'b1;
        if (ft_left > (cfg_in.exp_time + CNT_ONE)) begin
          dly_load = 1'b1;
          dly_len  = ft_left - cfg_in.exp_time - CNT_ONE;
        end else begin
          exp_on_d = 1'b1;
          exp_load = 1'b1;
        end
      end
      if (dly_done) begin
        exp_on_d = 1'b1;
        exp_load = 1'b1;
      end
      // Finished exposure starts sampling only after readout ends; otherwise it waits
      if (exp_done) begin
        exposed_d = 1'b1;
        exp_on_d  = 1'b0;
      end
      if ((exp_done || exposed_q) && fr_q != FR_SAMPLE
          && (fr_q != FR_READ || rd_last)) begin
        start_global_sample_state = 1'b1;
        exposed_d  = 1'b0;
        wait_d     = 1'b0;
        if (left_q != 8'h00) begin
          left_d = left_q - 8'h01;
        end
      end
    end

    if (start_global_sample_state) begin
      fr_d      = FR_SAMPLE;
      corrupt_d = global_sample_state_bad;
    end else if (rd_done) begin
      fr_d = FR_IDLE;
    end
  end

  always_ff @(posedge clk_in or posedge rst_all) begin
    if (rst_all) begin
      fr_q      <= FR_IDLE;
      exp_on_q  <= 1'b0;
      wait_q    <= 1'b0;
      corrupt_q <= 1'b0;
      exposed_q <= 1'b0;
      left_q    <= 8'h00;
    end else begin
      fr_q      <= fr_d;
      exp_on_q  <= exp_on_d;
      wait_q    <= wait_d;
      corrupt_q <= corrupt_d;
      exposed_q <= exposed_d;
      left_q    <= left_d;
    end
  end

  always_comb begin
    status_out.exposing            = exp_on_q;
    status_out.global_sample_state = (fr_q == FR_SAMPLE);
    status_out.readout             = (fr_q == FR_READ);
    status_out.idle                = (fr_q == FR_IDLE) && !exp_on_q && !dly_busy;
    status_out.corrupt             = corrupt_q;
    status_out.frames_left         = left_q;
  end
endmodule

// ===== efcs_pkg.sv
// Package for the exposure and frame control sequencer: modes, states, widths, limits, configuration and status types
// Assumes a single pixel clock domain; shared by all sequencer files
package efcs_pkg;

  localparam int unsigned CNT_W        = 24;
  localparam int unsigned SEQ_W        = 8;
  localparam logic [7:0]  SEQ_MAX      = 8'hFF;
  localparam logic [CNT_W-1:0] CNT_ONE = 24'h000001;
  localparam logic [CNT_W-1:0] CNT_ZERO = 24'h000000;
  localparam int unsigned SYNC_STAGES  = 3;

  typedef enum logic [2:0] {
    MODE_FULL_EXT  = 3'h0,
    MODE_PROG_EXT  = 3'h1,
    MODE_TRIG_INT  = 3'h2,
    MODE_STREAM    = 3'h3,
    MODE_INLINE    = 3'h4
  } efcs_mode_t;

  // Frame path states, Gray ordered along idle, sample, readout
  typedef enum logic [1:0] {
    FR_IDLE   = 2'h0,
    FR_SAMPLE = 2'h1,
    FR_READ   = 2'h3
  } efcs_frame_t;

  typedef struct packed {
    efcs_mode_t       mode;
    logic [CNT_W-1:0] exp_time;
    logic [CNT_W-1:0] frame_time;
    logic [CNT_W-1:0] sample_len;
    logic [CNT_W-1:0] readout_len;
    logic [SEQ_W-1:0] seq_len;
  } efcs_cfg_t;

  typedef struct packed {
    logic       exposing;
    logic       global_sample_state;
    logic       readout;
    logic       idle;
    logic       corrupt;
    logic [7:0] frames_left;
  } efcs_status_t;

endpackage

// ===== efcs_edge_sync.sv
// Synchroniser and rising edge detector for one asynchronous request pin
// Assumes the pin is asynchronous to clk_in; output is a one-cycle pulse
`timescale 1ns/1ps
module efcs_edge_sync
  import efcs_pkg::*;
(
  input  wire logic clk_in,    // Pixel clock
  input  wire logic rst_in,    // Async reset, active high
  input  wire logic pin_in,    // Raw request pin
  output logic      rise_out   // One-cycle rising edge pulse
);
  logic [SYNC_STAGES-1:0] sync_q;
  logic [SYNC_STAGES-1:0] sync_d;
  logic                   level_q;
  logic                   level_d;

  always_comb begin
    sync_d  = {sync_q[SYNC_STAGES-2:0], pin_in};
    level_d = level_q;
    // A change counts once the second and third stages agree
    if (sync_q[1] == sync_q[2]) begin
      level_d = sync_q[2];
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      sync_q  <= '0;
      level_q <= 1'b0;
    end else begin
      sync_q  <= sync_d;
      level_q <= level_d;
    end
  end

  assign rise_out = level_d & ~level_q;
endmodule

// ===== efcs_timer.sv
// Loadable down counter that flags expiry of a programmed interval
// Assumes load has priority; expiry pulses once when the count reaches one
`timescale 1ns/1ps
module efcs_timer
  import efcs_pkg::*;
#(
  parameter int unsigned W = CNT_W
) (
  input  wire logic         clk_in,   // Pixel clock
  input  wire logic         rst_in,   // Async reset, active high
  input  wire logic         load_in,  // Start interval
  input  wire logic [W-1:0] len_in,   // Interval length in cycles
  input  wire logic         stop_in,  // Abandon interval
  output logic              done_out, // Pulse on last cycle of interval
  output logic              busy_out, // Interval running
  output logic [W-1:0]      left_out  // Cycles remaining
);
  logic [W-1:0] cnt_q;
  logic [W-1:0] cnt_d;

  always_comb begin
    cnt_d = cnt_q;
    if (load_in) begin
      cnt_d = len_in;
    end else if (stop_in || done_out) begin
      cnt_d = '0;
    end else if (cnt_q != '0) begin
      cnt_d = cnt_q - W'(1);
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  assign done_out = (cnt_q == W'(1)) && !load_in && !stop_in;
  assign busy_out = (cnt_q != '0);
  assign left_out = cnt_q;
endmodule

// ===== efcs_ctrl_model.sv
// Camera controller model: turns one-cycle go strobes into request pin pulses
// Assumes go strobes come at least 2*HOLD cycles apart
`timescale 1ns/1ps
module efcs_ctrl_model
  import efcs_pkg::*;
#(
  parameter int unsigned HOLD = 4
) (
  input  wire logic clk_in,               // Pixel clock
  input  wire logic rst_in,               // Reset
  input  wire logic exp_go_in,            // Issue exposure request
  input  wire logic frame_go_in,          // Issue frame request
  output logic      exposure_request_out, // Exposure pin
  output logic      frame_request_out     // Frame pin
);
  logic [7:0] e_q, e_d, f_q, f_d;
  // Pin high for HOLD cycles, then low for HOLD cycles
  always_comb begin
    e_d = exp_go_in ? 8'(2 * HOLD) : e_q - 8'(e_q != 8'h00);
    f_d = frame_go_in ? 8'(2 * HOLD) : f_q - 8'(f_q != 8'h00);
  end
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      e_q <= 8'h00;
      f_q <= 8'h00;
    end else begin
      e_q <= e_d;
      f_q <= f_d;
    end
  end
  assign exposure_request_out = e_q > 8'(HOLD);
  assign frame_request_out    = f_q > 8'(HOLD);
endmodule

// ===== efcs_seq_sva.sv
// Checker for sequencer state timing at the ports
// Assumes binding onto efcs_sequencer; one clock domain
`timescale 1ns/1ps
module efcs_seq_sva
  import efcs_pkg::*;
(
  input wire logic         clk_in,              // Pixel clock
  input wire logic         rst_in,              // Hard reset
  input wire logic         soft_rst_n_in,       // Soft reset
  input wire logic         exposure_request_in, // Exposure pin
  input wire logic         frame_request_in,    // Frame pin
  input wire efcs_cfg_t    cfg_in,              // Configuration
  input wire efcs_status_t status_out           // State
);
  logic             gs, rd, ex, fe;
  logic [CNT_W-1:0] g_q, g_d, r_q, r_d, e_q, e_d;
  assign gs = status_out.global_sample_state;
  assign rd = status_out.readout;
  assign ex = status_out.exposing;
  assign fe = cfg_in.mode == MODE_FULL_EXT;
  // Run length of each state
  always_comb begin
    g_d = gs ? g_q + CNT_ONE : CNT_ZERO;
    r_d = (rd && !gs) ? r_q + CNT_ONE : CNT_ZERO;
    e_d = ex ? e_q + CNT_ONE : CNT_ZERO;
  end
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      g_q <= CNT_ZERO;
      r_q <= CNT_ZERO;
      e_q <= CNT_ZERO;
    end else begin
      g_q <= g_d;
      r_q <= r_d;
      e_q <= e_d;
    end
  end
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in || !soft_rst_n_in);
  sequence s_read_start;
    $rose(rd);
  endsequence
  sequence s_sample_end;
    $fell(gs);
  endsequence
  sequence s_exp_end;
    $fell(ex);
  endsequence
  a_exp_start: assert property (fe && $rose(exposure_request_in)
    |-> ##[2:6] ex) else $error("exposure not entered");
  a_frame_sample: assert property (fe && $rose(frame_request_in)
    |-> ##[2:6] gs) else $error("sampling not entered");
  a_exp_end_full: assert property (fe ##0 s_exp_end |-> gs)
    else $error("exposure ended without sampling");
  a_prog_exp_len: assert property (cfg_in.mode == MODE_PROG_EXT ##0 s_exp_end
    |-> gs && e_q == cfg_in.exp_time) else $error("programmed exposure length");
  a_sample_read: assert property (s_sample_end |-> rd)
    else $error("sampling not followed by readout");
  a_sample_len: assert property (s_read_start
    |-> g_q == cfg_in.sample_len || status_out.corrupt) else $error("sampling length");
  a_read_len: assert property ($fell(rd) && !gs |-> r_q == cfg_in.readout_len)
    else $error("readout length");
  a_idle_clean: assert property (status_out.idle |-> !(ex || gs || rd))
    else $error("idle while busy");
endmodule

bind efcs_sequencer efcs_seq_sva u_efcs_seq_sva (.clk_in, .rst_in, .soft_rst_n_in,
  .exposure_request_in, .frame_request_in, .cfg_in, .status_out);

// ===== tb.sv
// Self-checking bench for the sequencer in all control modes
// Assumes the controller model drives both request pins
`timescale 1ns/1ps
module tb
  import efcs_pkg::*;
;
  typedef struct packed {
    logic             g;
    logic [CNT_W-1:0] gap;
    logic             bad;
  } efcs_note_t;
  logic             clk_in, rst_in, soft_rst_n_in, exp_go, frm_go, exp_pin, frm_pin;
  logic             g_was, r_was;
  logic [31:0]      seed;
  logic [CNT_W-1:0] cyc, last_g, gap;
  efcs_cfg_t        cfg;
  efcs_status_t     st;
  efcs_note_t       notes[$];
  efcs_note_t       nt;
  int               errors, n_tests;

  efcs_sequencer u_efcs_sequencer (.clk_in, .rst_in, .soft_rst_n_in,
    .exposure_request_in(exp_pin), .frame_request_in(frm_pin), .cfg_in(cfg), .status_out(st));
  efcs_ctrl_model u_efcs_ctrl_model (.clk_in, .rst_in, .exp_go_in(exp_go),
    .frame_go_in(frm_go), .exposure_request_out(exp_pin), .frame_request_out(frm_pin));

  initial begin
    clk_in = 1'b0;
    forever #12.5 clk_in = ~clk_in;
  end

  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  task automatic chk(input string what, input logic [CNT_W-1:0] exp, got);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %s expected %0d seen %0d", what, exp, got);
    end
  endtask
  task automatic complete_run;
    if (errors == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_in);
  endtask
  // Spaced so that each pin pulse ends before the next request
  task automatic pulse(input logic frame);
    @(posedge clk_in);
    if (frame) frm_go <= 1'b1;
    else exp_go <= 1'b1;
    @(posedge clk_in);
    frm_go <= 1'b0;
    exp_go <= 1'b0;
    tick(7);
  endtask
  task automatic note(input logic g, input logic [CNT_W-1:0] gp, input logic bad);
    notes.push_back('{g, gp, bad});
  endtask
  task automatic settle(input int n);
    int k;
    k = 0;
    while ((notes.size() > n || (n == 0 && st.idle !== 1'b1)) && k < 3000) begin
      @(posedge clk_in);
      k++;
    end
    chk("frames owed", CNT_W'(n), CNT_W'(notes.size()));
    if (n == 0) chk("idle", CNT_ONE, CNT_W'(st.idle));
  endtask

  // Each readout start consumes the oldest expected frame
  always @(posedge clk_in) begin
    cyc = cyc + CNT_ONE;
    if (st.global_sample_state === 1'b1 && !g_was) begin
      gap = cyc - last_g;
      last_g = cyc;
    end
    if (st.readout === 1'b1 && !r_was) begin
      chk("frame expected", CNT_ONE, CNT_W'(notes.size() != 0));
      if (notes.size() != 0) begin
        nt = notes.pop_front();
        chk("corrupt", CNT_W'(nt.bad), CNT_W'(st.corrupt));
        if (nt.g) chk("frame gap", nt.gap, gap);
      end
    end
    g_was = st.global_sample_state === 1'b1;
    r_was = st.readout === 1'b1;
  end

  initial begin
    tick(20000);
    errors++;
    complete_run();
  end

  initial begin
    {rst_in, soft_rst_n_in, exp_go, frm_go, g_was, r_was} = 6'h30;
    errors = 0;
    n_tests = 0;
    seed = 32'h00012B31;
    cyc = CNT_ZERO;
    last_g = CNT_ZERO;
    gap = CNT_ZERO;
    cfg = '{MODE_FULL_EXT, 24'h00000A, 24'h000028, 24'h000006, 24'h000014, 8'h02};
    tick(4);
    chk("reset state", CNT_W'(13'h0200), CNT_W'(st));
    rst_in <= 1'b0;
    for (int i = 0; i < 3; i++) begin
      seed = xs(seed);
      note(1'b0, CNT_ZERO, 1'b0);
      pulse(1'b0);
      tick(seed[3:0]);
      pulse(1'b1);
      settle(0);
    end
    note(1'b0, CNT_ZERO, 1'b0);
    pulse(1'b0);
    pulse(1'b0);
    pulse(1'b1);
    settle(0);
    note(1'b0, CNT_ZERO, 1'b0);
    note(1'b0, CNT_ZERO, 1'b0);
    note(1'b0, CNT_ZERO, 1'b1);
    pulse(1'b0);
    pulse(1'b1);
    pulse(1'b0);
    tick(2);
    pulse(1'b1);
    tick(2);
    pulse(1'b1);
    settle(0);
    note(1'b0, CNT_ZERO, 1'b1);
    pulse(1'b1);
    settle(0);
    pulse(1'b0);
    soft_rst_n_in <= 1'b0;
    tick(2);
    chk("soft reset state", CNT_W'(13'h0200), CNT_W'(st));
    soft_rst_n_in <= 1'b1;
    cfg.mode <= MODE_PROG_EXT;
    note(1'b0, CNT_ZERO, 1'b0);
    pulse(1'b0);
    pulse(1'b1);
    settle(0);
    pulse(1'b1);
    chk("frame ignored", CNT_ONE, CNT_W'(st.idle));
    note(1'b0, CNT_ZERO, 1'b0);
    note(1'b0, CNT_ZERO, 1'b0);
    pulse(1'b0);
    tick(14);
    pulse(1'b0);
    settle(0);
    cfg.mode <= MODE_TRIG_INT;
    cfg.exp_time <= 24'h000014;
    for (int i = 0; i < 2; i++) begin
      cfg.frame_time <= i ? 24'h000028 : 24'h00001A;
      tick(1);
      note(1'b0, CNT_ZERO, 1'b0);
      note(1'b1, cfg.frame_time, 1'b0);
      pulse(1'b0);
      pulse(1'b1);
      settle(0);
    end
    note(1'b0, CNT_ZERO, 1'b0);
    for (int i = 0; i < 3; i++) note(1'b1, 24'h000028, 1'b0);
    pulse(1'b0);
    pulse(1'b0);
    settle(0);
    cfg.frame_time <= 24'h00003C;
    for (int i = 0; i < 2; i++) begin
      cfg.exp_time <= i ? 24'h000032 : 24'h000014;
      note(1'b0, CNT_ZERO, 1'b0);
      note(1'b1, 24'h00003C, 1'b0);
      note(i == 0, 24'h00003C, 1'b0);
      note(1'b1, 24'h00003C, 1'b0);
      pulse(1'b0);
      settle(2);
      tick(8);
      pulse(1'b0);
      settle(0);
    end
    for (int m = 3; m <= 4; m++) begin
      cfg.mode <= efcs_mode_t'(m);
      pulse(1'b0);
      chk("inert mode", CNT_ONE, CNT_W'(st.idle));
    end
    complete_run();
  end
endmodule
